// ===== hdl/smb_defs.svh
// register offsets, field positions, reset values and timing counts of the monitor bank
`ifndef SMB_DEFS_SVH
`define SMB_DEFS_SVH

// ------------------------------------------------------------
// register pointer values
// ------------------------------------------------------------
`define SMB_PTR_CONFIG 8'h00
`define SMB_PTR_SHUNT 8'h01
`define SMB_PTR_BUS 8'h02
`define SMB_PTR_POWER 8'h03
`define SMB_PTR_CURRENT 8'h04
`define SMB_PTR_CAL 8'h05

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define SMB_CONFIG_RESET 16'h399f
`define SMB_CAL_RESET 16'h0000
`define SMB_RESULT_RESET 16'h0000

// ------------------------------------------------------------
// configuration word fields
// ------------------------------------------------------------
`define SMB_RST_BIT 15
`define SMB_RANGE_BIT 13
`define SMB_GAIN_HI 12
`define SMB_GAIN_LO 11
`define SMB_BUSCONV_HI 10
`define SMB_BUSCONV_LO 7
`define SMB_SHCONV_HI 6
`define SMB_SHCONV_LO 3
`define SMB_MODE_HI 2
`define SMB_MODE_LO 0
`define SMB_MODE_POWER_DOWN 3'h0
`define SMB_MODE_ADC_OFF 3'h4

// ------------------------------------------------------------
// shunt scaling and converter decode
// ------------------------------------------------------------
`define SMB_SHUNT_FS 16'h0fa0
`define SMB_RES_BASE 4'h9
`define SMB_RES_FULL 4'hc

// ------------------------------------------------------------
// timing and serial address
// ------------------------------------------------------------
`define SMB_CLK_NS 10
`define SMB_APPLY_NS 4000
`define SMB_APPLY_CYC (`SMB_APPLY_NS / `SMB_CLK_NS)
`define SMB_SLAVE_ADDR 7'h40

`endif

// ===== hdl/smb_pkg.sv
// types shared by the monitor register bank
package smb_pkg;

  typedef logic [15:0] smb_word_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_PTR,
    ST_WR_MSB,
    ST_WR_LSB,
    ST_SKIP,
    ST_RD
  } smb_state_t;

endpackage

// ===== hdl/smb_regbank.sv
// monitor register bank behind a two-wire serial slave port
//
// Summary of operation
// - written contents take effect well within 4 us of the write completing.
// - pointer 00 to 05 selects configuration, shunt, bus, power, current, calibration.
// - power and current read zero after reset and while calibration is zero.
// - each 16-bit register moves as two bytes, high byte first.
// - configuration loads 399f on reset.
// - writing one to bit 15 resets every register; the bit clears itself.
// - bit 13 picks 16 V range at zero, 32 V at one, default one.
// - bits 12 and 11 pick gain 1, /2, /4, /8; default /8.
// - bits 10 to 7 set bus converter resolution or averaging.
// - bits 6 to 3 set shunt converter resolution or averaging.
// - top bit zero picks 9 to 12 bits; 1000 is 12 bits; above averages 2-128.
// - mode bits default to continuous shunt and bus measurement.
// - 000 powers down, 001-011 trigger, 100 stops converter, 101-111 run continuously.
// - shunt result is positioned by gain with all sign bits equal.
// - negative shunt readings are two's complement, sign extended to 16 bits.
// - gain /8 full scale reads 7d00 and 8300.
// - gain /4 full scale reads 3e80 and c180.
// - gain /2 full scale reads 1f40 and e0c0.
// - gain 1 full scale reads 0fa0 and f060.
// - bus result is read only and holds the latest bus measurement.
// - calibration is read-write, resets to zero, and feeds current and power scaling.
// - reads come from the register last chosen by a pointer write.
`include "smb_defs.svh"

module smb_regbank #(
  parameter logic [6:0] SLAVE_ADDR = `SMB_SLAVE_ADDR
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // serial pins, data line open drain
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // converter results
  input wire logic signed [15:0] shunt_drop_reading,
  input wire logic shunt_valid,
  input wire logic [15:0] bus_reading,
  input wire logic bus_valid,
  input wire logic [15:0] current_value,
  input wire logic [15:0] power_value,
  input wire logic product_valid,
  // converter controls
  output logic bus_range_select,
  output logic [1:0] shunt_gain_stage,
  output logic [3:0] bus_resolution,
  output logic [2:0] bus_avg_log2,
  output logic [3:0] shunt_resolution,
  output logic [2:0] shunt_avg_log2,
  output logic shunt_run,
  output logic bus_run,
  output logic shunt_trigger,
  output logic bus_trigger,
  output logic powered_down,
  output logic adc_disabled,
  output logic [15:0] scale_calibration
);

  // ------------------------------------------------------------
  // converter setting decode
  // ------------------------------------------------------------
  // returns {resolution in bits, log2 of averaged samples}
  function automatic logic [6:0] conv_decode(input logic [3:0] s);
    logic [6:0] r;
    r = {`SMB_RES_FULL, 3'h0};
    if (!s[3])
    begin
      r = {4'(`SMB_RES_BASE + {2'h0, s[1:0]}), 3'h0};
    end
    else
    begin
      r = {`SMB_RES_FULL, s[2:0]};
    end
    return r;
  endfunction

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic scl_m, scl_s, scl_d;
  logic sda_m, sda_s, sda_d;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_m <= scl_i;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_i;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
  assign bus_stop = scl_s & scl_d & ~sda_d & sda_s;
  assign sda_o = 1'b0;

  // ------------------------------------------------------------
  // registers and read mux
  // ------------------------------------------------------------
  smb_pkg::smb_word_t configuration_word, next_config;
  smb_pkg::smb_word_t shunt_voltage_result, next_shunt;
  smb_pkg::smb_word_t bus_voltage_result, next_bus;
  smb_pkg::smb_word_t power_result, next_power;
  smb_pkg::smb_word_t current_result, next_current;
  smb_pkg::smb_word_t cal_word, next_cal;
  smb_pkg::smb_word_t read_word, fmt_word;
  logic next_trig_s, next_trig_b;

  // ------------------------------------------------------------
  // serial engine state
  // ------------------------------------------------------------
  smb_pkg::smb_state_t state, next_state;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [7:0] shift, next_shift;
  logic [7:0] pointer, next_pointer;
  logic [7:0] msb_hold, next_msb;
  smb_pkg::smb_word_t tx_word, next_tx;
  smb_pkg::smb_word_t wr_data, next_wr_data;
  logic byte_sel, next_byte_sel;
  logic next_oe, wr_pend, next_wr_pend;
  logic [7:0] tx_byte;
  logic addr_hit;

  // unknown pointers read as zero
  always_comb
  begin
    if (pointer == `SMB_PTR_CONFIG)
    begin
      read_word = configuration_word;
    end
    else if (pointer == `SMB_PTR_SHUNT)
    begin
      read_word = shunt_voltage_result;
    end
    else if (pointer == `SMB_PTR_BUS)
    begin
      read_word = bus_voltage_result;
    end
    else if (pointer == `SMB_PTR_POWER)
    begin
      read_word = power_result;
    end
    else if (pointer == `SMB_PTR_CURRENT)
    begin
      read_word = current_result;
    end
    else if (pointer == `SMB_PTR_CAL)
    begin
      read_word = cal_word;
    end
    else
    begin
      read_word = `SMB_RESULT_RESET;
    end
  end

  assign tx_byte = byte_sel ? tx_word[7:0] : tx_word[15:8];
  assign addr_hit = (shift[7:1] == SLAVE_ADDR);

  always_comb
  begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    next_pointer = pointer;
    next_msb = msb_hold;
    next_tx = tx_word;
    next_byte_sel = byte_sel;
    next_oe = sda_oe;
    next_wr_pend = 1'b0;
    next_wr_data = wr_data;
    if (bus_stop)
    begin
      next_state = smb_pkg::ST_IDLE;
      next_oe = 1'b0;
    end
    else if (bus_start)
    begin
      next_state = smb_pkg::ST_ADDR;
      next_bit_cnt = 4'h0;
      next_oe = 1'b0;
    end
    else if (scl_rise && state != smb_pkg::ST_IDLE)
    begin
      if (bit_cnt < 4'h8)
      begin
        next_shift = {shift[6:0], sda_s};
        next_bit_cnt = bit_cnt + 4'h1;
      end
      else
      begin
        next_bit_cnt = 4'h0;
        case (state)
          smb_pkg::ST_ADDR:
          begin
            if (!addr_hit)
            begin
              next_state = smb_pkg::ST_IDLE;
            end
            else if (shift[0])
            begin
              next_state = smb_pkg::ST_RD;
              next_tx = read_word;
              next_byte_sel = 1'b0;
            end
            else
            begin
              next_state = smb_pkg::ST_PTR;
            end
          end
          smb_pkg::ST_PTR:
          begin
            next_pointer = shift;
            next_state = smb_pkg::ST_WR_MSB;
          end
          smb_pkg::ST_WR_MSB:
          begin
            next_msb = shift;
            next_state = smb_pkg::ST_WR_LSB;
          end
          smb_pkg::ST_WR_LSB:
          begin
            next_wr_data = {msb_hold, shift};
            next_wr_pend = 1'b1;
            next_state = smb_pkg::ST_SKIP;
          end
          smb_pkg::ST_RD:
          begin
            // master not-acknowledge ends the read
            if (sda_s)
            begin
              next_state = smb_pkg::ST_IDLE;
            end
            else
            begin
              next_byte_sel = ~byte_sel;
            end
          end
          default:
          begin
            next_state = state;
          end
        endcase
      end
    end
    else if (scl_fall && state != smb_pkg::ST_IDLE)
    begin
      if (bit_cnt == 4'h8)
      begin
        // extra written bytes are not acknowledged
        next_oe = (state == smb_pkg::ST_ADDR && addr_hit) || state == smb_pkg::ST_PTR ||
                  state == smb_pkg::ST_WR_MSB || state == smb_pkg::ST_WR_LSB;
      end
      else if (state == smb_pkg::ST_RD)
      begin
        next_oe = ~tx_byte[~bit_cnt[2:0]];
      end
      else
      begin
        next_oe = 1'b0;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state <= smb_pkg::ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      pointer <= `SMB_PTR_CONFIG;
      msb_hold <= 8'h00;
      tx_word <= `SMB_RESULT_RESET;
      byte_sel <= 1'b0;
      sda_oe <= 1'b0;
      wr_pend <= 1'b0;
      wr_data <= `SMB_RESULT_RESET;
    end
    else
    begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      pointer <= next_pointer;
      msb_hold <= next_msb;
      tx_word <= next_tx;
      byte_sel <= next_byte_sel;
      sda_oe <= next_oe;
      wr_pend <= next_wr_pend;
      wr_data <= next_wr_data;
    end
  end

  // ------------------------------------------------------------
  // register update
  // ------------------------------------------------------------
  smb_shunt_fmt u_fmt (
    .gain(configuration_word[`SMB_GAIN_HI:`SMB_GAIN_LO]),
    .raw(shunt_drop_reading),
    .word(fmt_word)
  );

  // a write commits one cycle after its last byte, far inside the settle time
  always_comb
  begin
    next_config = configuration_word;
    next_cal = cal_word;
    next_shunt = shunt_voltage_result;
    next_bus = bus_voltage_result;
    next_power = power_result;
    next_current = current_result;
    next_trig_s = 1'b0;
    next_trig_b = 1'b0;
    if (shunt_valid)
    begin
      next_shunt = fmt_word;
    end
    if (bus_valid)
    begin
      next_bus = bus_reading;
    end
    if (product_valid)
    begin
      next_power = power_value;
      next_current = current_value;
    end
    if (wr_pend && pointer == `SMB_PTR_CONFIG)
    begin
      if (wr_data[`SMB_RST_BIT])
      begin
        next_config = `SMB_CONFIG_RESET;
        next_cal = `SMB_CAL_RESET;
        next_shunt = `SMB_RESULT_RESET;
        next_bus = `SMB_RESULT_RESET;
      end
      else
      begin
        next_config = wr_data;
        next_trig_s = ~wr_data[2] & wr_data[0];
        next_trig_b = ~wr_data[2] & wr_data[1];
      end
    end
    else if (wr_pend && pointer == `SMB_PTR_CAL)
    begin
      next_cal = wr_data;
    end
    // writes to other pointers fall through untouched
    if (next_cal == `SMB_CAL_RESET)
    begin
      next_power = `SMB_RESULT_RESET;
      next_current = `SMB_RESULT_RESET;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      configuration_word <= `SMB_CONFIG_RESET;
      cal_word <= `SMB_CAL_RESET;
      shunt_voltage_result <= `SMB_RESULT_RESET;
      bus_voltage_result <= `SMB_RESULT_RESET;
      power_result <= `SMB_RESULT_RESET;
      current_result <= `SMB_RESULT_RESET;
      shunt_trigger <= 1'b0;
      bus_trigger <= 1'b0;
    end
    else
    begin
      configuration_word <= next_config;
      cal_word <= next_cal;
      shunt_voltage_result <= next_shunt;
      bus_voltage_result <= next_bus;
      power_result <= next_power;
      current_result <= next_current;
      shunt_trigger <= next_trig_s;
      bus_trigger <= next_trig_b;
    end
  end

  // ------------------------------------------------------------
  // converter controls
  // ------------------------------------------------------------
  assign bus_range_select = configuration_word[`SMB_RANGE_BIT];
  assign shunt_gain_stage = configuration_word[`SMB_GAIN_HI:`SMB_GAIN_LO];
  assign {bus_resolution, bus_avg_log2} =
    conv_decode(configuration_word[`SMB_BUSCONV_HI:`SMB_BUSCONV_LO]);
  assign {shunt_resolution, shunt_avg_log2} =
    conv_decode(configuration_word[`SMB_SHCONV_HI:`SMB_SHCONV_LO]);
  assign shunt_run = configuration_word[2] & configuration_word[0];
  assign bus_run = configuration_word[2] & configuration_word[1];
  assign powered_down = configuration_word[`SMB_MODE_HI:`SMB_MODE_LO] == `SMB_MODE_POWER_DOWN;
  assign adc_disabled = configuration_word[`SMB_MODE_HI:`SMB_MODE_LO] == `SMB_MODE_ADC_OFF;
  assign scale_calibration = cal_word;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  localparam int apply_cyc = `SMB_APPLY_CYC;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  cfg_apply_a: assert property (wr_pend && pointer == `SMB_PTR_CONFIG && !wr_data[15] |-> ##[1:apply_cyc] configuration_word == wr_data)
    else $error("configuration write not applied in time");
  reset_value_a: assert property ($past(srst) |-> configuration_word == 16'h399f && cal_word == 16'h0000)
    else $error("reset values wrong");
  soft_reset_a: assert property (wr_pend && pointer == `SMB_PTR_CONFIG && wr_data[15] |=> configuration_word == 16'h399f && !configuration_word[15] && cal_word == 16'h0000)
    else $error("self-clearing reset failed");
  cal_zero_a: assert property (cal_word == 16'h0000 |-> power_result == 16'h0000 && current_result == 16'h0000)
    else $error("results not zero without calibration");
  ro_ignore_a: assert property (wr_pend && pointer == `SMB_PTR_BUS && !bus_valid |=> $stable(bus_voltage_result))
    else $error("read-only register was written");
  read_snap_a: assert property (state != smb_pkg::ST_RD ##1 state == smb_pkg::ST_RD |-> tx_word == $past(read_word) && !byte_sel)
    else $error("read word not taken from pointer");
  gain8_clip_a: assert property (shunt_valid && shunt_gain_stage == 2'h3 && shunt_drop_reading > 16'sd32000 |=> shunt_voltage_result == 16'h7d00)
    else $error("gain 8 positive clip wrong");
  gain4_clip_a: assert property (shunt_valid && shunt_gain_stage == 2'h2 && shunt_drop_reading < -16'sd16000 |=> shunt_voltage_result == 16'hc180)
    else $error("gain 4 negative clip wrong");
  gain2_clip_a: assert property (shunt_valid && shunt_gain_stage == 2'h1 && shunt_drop_reading > 16'sd8000 |=> shunt_voltage_result == 16'h1f40)
    else $error("gain 2 positive clip wrong");
  gain1_sign_a: assert property (shunt_valid && shunt_gain_stage == 2'h0 && !wr_pend |=>
    shunt_voltage_result[15:12] == 4'h0 || shunt_voltage_result[15:12] == 4'hf)
    else $error("gain 1 sign bits differ");
  trig_pulse_a: assert property (wr_pend && pointer == `SMB_PTR_CONFIG && wr_data[2:0] == 3'h3 && !wr_data[15] |=> shunt_trigger && bus_trigger ##1 !shunt_trigger)
    else $error("triggered mode pulse wrong");
  avg_decode_a: assert property (configuration_word[10:7] == 4'hf |-> bus_avg_log2 == 3'h7 && bus_resolution == 4'hc)
    else $error("converter decode wrong");

  write_cov: cover property (wr_pend && pointer == `SMB_PTR_CAL);
  read_cov: cover property (state == smb_pkg::ST_RD && byte_sel && scl_rise && !sda_s);
  soft_rst_cov: cover property (wr_pend && wr_data[15] && pointer == `SMB_PTR_CONFIG);
  clip_cov: cover property (shunt_valid && shunt_drop_reading < -16'sd4000);

endmodule

// ===== hdl/smb_shunt_fmt.sv
// shunt reading formatter: clamps to the gain's full scale, keeps two's complement
`include "smb_defs.svh"

module smb_shunt_fmt (
  // gain code and raw reading in 10 uV steps
  input wire logic [1:0] gain,
  input wire logic signed [15:0] raw,
  // register image
  output logic [15:0] word
);

  logic [15:0] limit;
  logic [15:0] neg_limit;

  // ------------------------------------------------------------
  // clamp
  // ------------------------------------------------------------
  // smaller gain codes saturate earlier, so the unused top bits copy the sign
  always_comb
  begin
    limit = 16'(`SMB_SHUNT_FS << gain);
    neg_limit = 16'(16'h0000 - limit);
    if (raw > $signed(limit))
    begin
      word = limit;
    end
    else if (raw < $signed(neg_limit))
    begin
      word = neg_limit;
    end
    else
    begin
      word = raw;
    end
  end

endmodule

// ===== tb/shunt_monitor_register_bank_test.sv
// self-checking bench for the monitor register bank
module shunt_monitor_register_bank_test;
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic scl, sda_low, sda, sda_o, sda_oe, ack;
  logic signed [15:0] shunt_drop_reading = 16'sh0000;
  logic shunt_valid = 1'b0;
  logic bus_valid = 1'b0;
  logic product_valid = 1'b0;
  logic [15:0] bus_reading = 16'h0000;
  logic [15:0] current_value = 16'h0000;
  logic [15:0] power_value = 16'h0000;
  logic bus_range_select, shunt_run, bus_run, shunt_trigger, bus_trigger;
  logic powered_down, adc_disabled;
  logic [1:0] shunt_gain_stage;
  logic [3:0] bus_resolution, shunt_resolution;
  logic [2:0] bus_avg_log2, shunt_avg_log2;
  logic [15:0] scale_calibration, rdata;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  int shunt_trigs = 0;
  int bus_trigs = 0;

  always #5 clk = ~clk;

  // open-drain data line with pull-up
  assign sda = ~(sda_low | (sda_oe & ~sda_o));

  smb_regbank u_smb_regbank (
    .clk(clk), .srst(srst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .shunt_drop_reading(shunt_drop_reading), .shunt_valid(shunt_valid),
    .bus_reading(bus_reading), .bus_valid(bus_valid), .current_value(current_value),
    .power_value(power_value), .product_valid(product_valid),
    .bus_range_select(bus_range_select), .shunt_gain_stage(shunt_gain_stage),
    .bus_resolution(bus_resolution), .bus_avg_log2(bus_avg_log2),
    .shunt_resolution(shunt_resolution), .shunt_avg_log2(shunt_avg_log2),
    .shunt_run(shunt_run), .bus_run(bus_run), .shunt_trigger(shunt_trigger),
    .bus_trigger(bus_trigger), .powered_down(powered_down), .adc_disabled(adc_disabled),
    .scale_calibration(scale_calibration)
  );

  smb_i2c_master u_smb_i2c_master (.scl(scl), .sda_low(sda_low), .sda(sda));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // trigger pulses last one cycle, so they are counted rather than sampled
  always @(posedge clk)
  begin
    cycles++;
    shunt_trigs += int'(shunt_trigger === 1'b1);
    bus_trigs += int'(bus_trigger === 1'b1);
    if (cycles == 90000)
    begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic pulse(input int which);
    @(posedge clk);
    shunt_valid <= (which == 0);
    bus_valid <= (which == 1);
    product_valid <= (which == 2);
    @(posedge clk);
    {shunt_valid, bus_valid, product_valid} <= 3'h0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    u_smb_i2c_master.write_word(p, d, 1'b1, ack);
    check("write ack", 16'h0001, {15'h0, ack});
  endtask

  // the pointer is always rewritten first, so no settle wait is needed before a read-back
  task automatic rd_chk(input string what, input logic [7:0] p, input logic [15:0] exp);
    u_smb_i2c_master.write_word(p, 16'h0000, 1'b0, ack);
    check("pointer ack", 16'h0001, {15'h0, ack});
    u_smb_i2c_master.read_word(rdata, ack);
    check(what, exp, rdata);
  endtask

  function automatic logic [6:0] res_of(input logic [3:0] s);
    if (!s[3])
      return {4'h9 + {2'h0, s[1:0]}, 3'h0};
    return (s == 4'h8) ? {4'hc, 3'h0} : {4'hc, s[2:0]};
  endfunction

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic test_reset;
    check("defaults", 16'h001f, {11'h0, bus_range_select, shunt_gain_stage, shunt_run, bus_run});
    check("res", 16'h3060, {2'h0, bus_resolution, bus_avg_log2, shunt_resolution, shunt_avg_log2});
    rd_chk("config", 8'h00, 16'h399f);
    rd_chk("cal", 8'h05, 16'h0000);
    rd_chk("power", 8'h03, 16'h0000);
    rd_chk("current", 8'h04, 16'h0000);
  endtask

  task automatic test_config;
    logic [15:0] cfg;
    logic [3:0] bs;
    int st, bt;
    for (int i = 0; i < 16; i++)
    begin
      bs = 4'(i);
      cfg = {2'b00, bs[0], bs[2:1], bs, ~bs, bs[2:0]};
      st = shunt_trigs;
      bt = bus_trigs;
      wr(8'h00, cfg);
      repeat (4) @(posedge clk);
      check("range", {15'h0, bs[0]}, {15'h0, bus_range_select});
      check("gain", {14'h0, bs[2:1]}, {14'h0, shunt_gain_stage});
      check("bus res", {9'h0, res_of(bs)}, {9'h0, bus_resolution, bus_avg_log2});
      check("shunt res", {9'h0, res_of(~bs)}, {9'h0, shunt_resolution, shunt_avg_log2});
      check("mode", {10'h0, bs[2:0] == 3'h0, bs[2:0] == 3'h4, bs[2] & bs[0], bs[2] & bs[1],
            ~bs[2] & bs[0], ~bs[2] & bs[1]}, {10'h0, powered_down, adc_disabled, shunt_run,
            bus_run, shunt_trigs - st == 1, bus_trigs - bt == 1});
      rd_chk("config", 8'h00, cfg);
    end
  endtask

  task automatic test_shunt;
    logic [15:0] pos[4] = '{16'h0fa0, 16'h1f40, 16'h3e80, 16'h7d00};
    logic [15:0] neg[4] = '{16'hf060, 16'he0c0, 16'hc180, 16'h8300};
    logic [15:0] raw[5], exp[5];
    for (int g = 0; g < 4; g++)
    begin
      wr(8'h00, {3'b001, 2'(g), 11'h19f});
      raw = '{pos[g], neg[g], pos[g] + 16'h0001, neg[g] - 16'h0001, 16'hffff};
      exp = '{pos[g], neg[g], pos[g], neg[g], 16'hffff};
      for (int k = 0; k < 5; k++)
      begin
        @(posedge clk);
        shunt_drop_reading <= raw[k];
        pulse(0);
        rd_chk("shunt", 8'h01, exp[k]);
      end
    end
  endtask

  task automatic test_products;
    @(posedge clk);
    current_value <= 16'h1234;
    power_value <= 16'h0567;
    pulse(2);
    rd_chk("power", 8'h03, 16'h0000);
    rd_chk("current", 8'h04, 16'h0000);
    wr(8'h05, 16'h4321);
    check("cal port", 16'h4321, scale_calibration);
    rd_chk("cal", 8'h05, 16'h4321);
    u_smb_i2c_master.read_word(rdata, ack);
    check("cal again", 16'h4321, rdata);
    pulse(2);
    rd_chk("power", 8'h03, 16'h0567);
    rd_chk("current", 8'h04, 16'h1234);
  endtask

  task automatic test_readonly;
    @(posedge clk);
    bus_reading <= 16'h1a2b;
    pulse(1);
    rd_chk("bus", 8'h02, 16'h1a2b);
    wr(8'h02, 16'hffff);
    wr(8'h03, 16'hffff);
    rd_chk("bus", 8'h02, 16'h1a2b);
    rd_chk("power", 8'h03, 16'h0567);
    rd_chk("unmapped", 8'h06, 16'h0000);
  endtask

  task automatic test_soft_reset;
    wr(8'h00, 16'h8123);
    repeat (4) @(posedge clk);
    check("range", 16'h0001, {15'h0, bus_range_select});
    check("cal port", 16'h0000, scale_calibration);
    rd_chk("config", 8'h00, 16'h399f);
    rd_chk("cal", 8'h05, 16'h0000);
    rd_chk("current", 8'h04, 16'h0000);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    test_reset();
    test_config();
    test_shunt();
    test_products();
    test_readonly();
    test_soft_reset();
    give_verdict();
  end
endmodule

// ===== tb/smb_i2c_master.sv
// two-wire bus master model driving the monitor's serial port
`include "smb_defs.svh"

module smb_i2c_master #(
  parameter logic [6:0] ADDR = `SMB_SLAVE_ADDR
) (
  // bus lines, data is pulled low only
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;

  // clock stands high and data released between frames
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // ------------------------------------------------------------
  // bit and byte level, 125 ns per bit
  // ------------------------------------------------------------
  // data moves well inside the low phase so the slave's synchronisers see it settled
  task automatic bit_io(input logic b, output logic s);
    #31 sda_low = ~b;
    #32 scl = 1'b1;
    #60 s = sda;
    #2 scl = 1'b0;
  endtask

  task automatic byte_io(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                         output logic ack_seen);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], s);
      q[i] = s;
    end
    bit_io(~ack_in, s);
    ack_seen = ~s;
  endtask

  task automatic start;
    #62 sda_low = 1'b1;
    #63 scl = 1'b0;
  endtask

  task automatic stop;
    #31 sda_low = 1'b1;
    #32 scl = 1'b1;
    #31 sda_low = 1'b0;
    #62;
  endtask

  // ------------------------------------------------------------
  // word transfers
  // ------------------------------------------------------------
  task automatic write_word(input logic [7:0] ptr, input logic [15:0] d, input logic with_data,
                            output logic ok);
    logic [7:0] q;
    logic a0, a1, a2, a3;
    a2 = 1'b1;
    a3 = 1'b1;
    start();
    byte_io({ADDR, 1'b0}, 1'b0, q, a0);
    byte_io(ptr, 1'b0, q, a1);
    if (with_data)
    begin
      byte_io(d[15:8], 1'b0, q, a2);
      byte_io(d[7:0], 1'b0, q, a3);
    end
    stop();
    ok = a0 & a1 & a2 & a3;
  endtask

  task automatic read_word(output logic [15:0] d, output logic ok);
    logic a;
    start();
    byte_io({ADDR, 1'b1}, 1'b0, d[7:0], ok);
    byte_io(8'hff, 1'b1, d[15:8], a);
    byte_io(8'hff, 1'b0, d[7:0], a);
    stop();
  endtask
endmodule
